/* File: twbc_ctl.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Cache controller end: runs one single or burst access per request
// ----------------------------------------------------------------
module twbc_ctl #(
  parameter int ADDR_W = twbc_pkg::ADDR_W,
  parameter int DATA_W = twbc_pkg::DATA_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // User request
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_bank_i,
  input wire logic req_burst_i,
  input wire logic [1:0] req_byte_en_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [twbc_pkg::BURST_LEN*DATA_W-1:0] wr_line_i,
  // User answer
  output logic busy_o,
  output logic done_o,
  output logic [twbc_pkg::BURST_LEN*DATA_W-1:0] rd_line_o,
  twbc_if.ctl link
);
  import twbc_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Widths must match the link, with two byte lanes of fixed width
  if (DATA_W != twbc_pkg::DATA_W || ADDR_W != twbc_pkg::ADDR_W || DATA_W != 2 * BYTE_W) begin : g_bad_param
    $error("twbc_ctl: unsupported width parameters");
  end

  // ----------------------------------------------------------------
  // State and request registers
  // ----------------------------------------------------------------
  twbc_state_type state_r;              // Sequencer state
  twbc_state_type state_nxt;
  logic write_r;                        // Access is a write
  logic bank_r;                         // Selected bank
  logic burst_r;                        // Four beats, else one
  logic [1:0] byte_en_r;                // Byte lanes, active high
  logic [ADDR_W-1:0] addr_r;            // Start address
  logic [BURST_LEN*DATA_W-1:0] line_r;  // Write line
  logic [OFFS_W-1:0] beat_r;            // Beats issued
  logic [OFFS_W-1:0] rd_idx_r;          // Read words caught
  logic [DATA_W-1:0] wr_data_r;         // Word on the write bus
  logic [BURST_LEN*DATA_W-1:0] rd_line_r;
  logic done_r;

  // Last beat of this access
  wire last_w = burst_r ? (beat_r == LAST_BEAT) : 1'b1;
  wire in_xfer_w = (state_r == TWBC_XFER);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TWBC_IDLE: begin
        if (req_i) begin
          state_nxt = TWBC_START;
        end
      end
      // Strobe with enables high initialises the RAM
      TWBC_START: begin
        state_nxt = TWBC_XFER;
      end
      TWBC_XFER: begin
        if (last_w) begin
          state_nxt = TWBC_FINISH;
        end
      end
      // Enables released to close the access
      TWBC_FINISH: begin
        state_nxt = TWBC_IDLE;
      end
      default: begin
        state_nxt = TWBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= TWBC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Request capture in idle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_r <= 1'b0;
      bank_r <= BANK_A;
      burst_r <= 1'b0;
      byte_en_r <= 2'h0;
      addr_r <= '0;
      line_r <= '0;
    end else if (state_r == TWBC_IDLE && req_i) begin
      write_r <= req_write_i;
      bank_r <= req_bank_i;
      burst_r <= req_burst_i;
      byte_en_r <= req_byte_en_i;
      addr_r <= req_addr_i;
      line_r <= wr_line_i;
    end
  end

  // Beat count and write word, next word after every beat
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      beat_r <= OFFS_RESET;
      wr_data_r <= '0;
    end else if (state_r == TWBC_START) begin
      beat_r <= OFFS_RESET;
      wr_data_r <= line_r[DATA_W-1:0];
    end else if (in_xfer_w) begin
      beat_r <= beat_r + 2'h1;
      wr_data_r <= line_r[(32'(beat_r) + 1) % BURST_LEN * DATA_W +: DATA_W];
    end
  end

  // Read words caught in arrival order, done one cycle after finish
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_idx_r <= OFFS_RESET;
      rd_line_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= (state_r == TWBC_FINISH);
      if (state_r == TWBC_START) begin
        rd_idx_r <= OFFS_RESET;
      end else if (link.rd_valid) begin
        rd_idx_r <= rd_idx_r + 2'h1;
        rd_line_r[32'(rd_idx_r) * DATA_W +: DATA_W] <= link.rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link drive
  // ----------------------------------------------------------------
  // Only one bank enable low at a time
  wire rd_act_w = in_xfer_w && !write_r;
  wire wr_act_w = in_xfer_w && write_r;
  assign link.bank_a_read_enable_n = !(rd_act_w && bank_r == BANK_A);
  assign link.bank_b_read_enable_n = !(rd_act_w && bank_r == BANK_B);
  assign link.bank_a_write_enable_n = !(wr_act_w && bank_r == BANK_A);
  assign link.bank_b_write_enable_n = !(wr_act_w && bank_r == BANK_B);
  // Strobe low only in the start cycle
  assign link.cycle_start_strobe_n = (state_r != TWBC_START);
  // Burst-continue low on every beat, also for writes
  assign link.burst_continue_n = !in_xfer_w;
  assign link.transfer_done_n = 1'b1;
  assign link.upper_byte_enable_n = !byte_en_r[1];
  assign link.lower_byte_enable_n = !byte_en_r[0];
  assign link.address = addr_r;
  assign link.wr_data = wr_data_r;

  // User side
  assign busy_o = (state_r != TWBC_IDLE);
  assign done_o = done_r;
  assign rd_line_o = rd_line_r;

endmodule

/* File: twbc_pkg.sv */
// ----------------------------------------------------------------
// Shared constants for the two-way burst cache data RAM
// ----------------------------------------------------------------
package twbc_pkg;

  // Word address width: 8K words per bank
  localparam int ADDR_W = 13;
  // Word width: two bytes of eight data bits plus one parity bit each
  localparam int DATA_W = 18;
  // Width of one byte lane including its parity bit
  localparam int BYTE_W = 9;
  // Number of banks (ways)
  localparam int NUM_BANKS = 2;
  // Burst offset width and burst length
  localparam int OFFS_W = 2;
  localparam int BURST_LEN = 4;
  // Position of the upper word address inside the full address
  localparam int UPPER_LSB = 2;
  // Last beat index of a full burst
  localparam logic [OFFS_W-1:0] LAST_BEAT = 2'h3;
  // Reset value of the burst count and start offset
  localparam logic [OFFS_W-1:0] OFFS_RESET = 2'h0;
  // Bank index values
  localparam logic BANK_A = 1'h0;
  localparam logic BANK_B = 1'h1;

  // Controller sequencer states, one-hot
  typedef enum logic [3:0] {
    TWBC_IDLE   = 4'h1,
    TWBC_START  = 4'h2,
    TWBC_XFER   = 4'h4,
    TWBC_FINISH = 4'h8
  } twbc_state_type;

endpackage

/* File: twbc_if.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Link between cache controller and cache data RAM
// ----------------------------------------------------------------
interface twbc_if;
  import twbc_pkg::*;

  // Cycle control strobes, all active low
  logic cycle_start_strobe_n;
  logic transfer_done_n;
  logic burst_continue_n;
  // Per-bank read and write enables, active low
  logic bank_a_read_enable_n;
  logic bank_b_read_enable_n;
  logic bank_a_write_enable_n;
  logic bank_b_write_enable_n;
  // Shared byte enables, active low
  logic upper_byte_enable_n;
  logic lower_byte_enable_n;
  // Word address: upper word address plus two burst offset bits
  logic [ADDR_W-1:0] address;
  // Write data towards the RAM
  logic [DATA_W-1:0] wr_data;
  // Read data from the RAM and its one-cycle valid mark
  logic [DATA_W-1:0] rd_data;
  logic rd_valid;

  // RAM end
  modport dev (
    input cycle_start_strobe_n, transfer_done_n, burst_continue_n,
    input bank_a_read_enable_n, bank_b_read_enable_n,
    input bank_a_write_enable_n, bank_b_write_enable_n,
    input upper_byte_enable_n, lower_byte_enable_n, address, wr_data,
    output rd_data, rd_valid
  );

  // Controller end
  modport ctl (
    output cycle_start_strobe_n, transfer_done_n, burst_continue_n,
    output bank_a_read_enable_n, bank_b_read_enable_n,
    output bank_a_write_enable_n, bank_b_write_enable_n,
    output upper_byte_enable_n, lower_byte_enable_n, address, wr_data,
    input rd_data, rd_valid
  );
endinterface

/* File: twbc_dev.sv */
`timescale 1ns/10ps
module twbc_dev #(
  parameter int ADDR_W = twbc_pkg::ADDR_W,
  parameter int DATA_W = twbc_pkg::DATA_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  twbc_if.dev link
);
  import twbc_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Widths must match the link, with two byte lanes of fixed width
  if (DATA_W != twbc_pkg::DATA_W || ADDR_W != twbc_pkg::ADDR_W || DATA_W != 2 * BYTE_W) begin : g_bad_param
    $error("twbc_dev: unsupported width parameters");
  end

  localparam int DEPTH = 1 << ADDR_W;
  localparam int UPPER_W = ADDR_W - OFFS_W;

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  // Active-high views of the enables
  wire rd_a_w = !link.bank_a_read_enable_n;
  wire rd_b_w = !link.bank_b_read_enable_n;
  wire wr_a_w = !link.bank_a_write_enable_n;
  wire wr_b_w = !link.bank_b_write_enable_n;
  // Byte lane requests
  wire lo_byte_w = !link.lower_byte_enable_n;
  wire hi_byte_w = !link.upper_byte_enable_n;
  // All four bank enables inactive
  wire all_high_w = !(rd_a_w || rd_b_w || wr_a_w || wr_b_w);
  // Any enable active
  wire any_low_w = !all_high_w;
  // Cycle start strobe active
  wire strobe_w = !link.cycle_start_strobe_n;
  // Either ready input active
  wire ready_w = !link.transfer_done_n || !link.burst_continue_n;

  // ----------------------------------------------------------------
  // Cycle state
  // ----------------------------------------------------------------
  logic active_r;                        // Cycle initialised, not ended
  logic active_nxt;
  logic engaged_r;                       // An enable went low this cycle
  logic engaged_nxt;
  logic [OFFS_W-1:0] start_off_r;        // Starting word offset
  logic [OFFS_W-1:0] count_r;            // Beats already taken
  logic [OFFS_W-1:0] count_nxt;
  logic [UPPER_W-1:0] upper_r;           // Held upper word address
  logic [DATA_W-1:0] rd_data_r;          // Read output register
  logic rd_valid_r;                      // Read word valid mark

  // Initialisation: strobe low while every enable is high
  wire init_w = strobe_w && all_high_w;

  // Beat: enable active, a ready low, strobe released
  wire beat_w = active_r && any_low_w && ready_w && !strobe_w;

  // Write pulse qualifies on byte enable too
  wire wr_any_w = wr_a_w || wr_b_w;
  wire wr_pulse_w = beat_w && wr_any_w && (lo_byte_w || hi_byte_w);

  // Read beat on either bank
  wire rd_any_w = rd_a_w || rd_b_w;
  wire rd_beat_w = beat_w && rd_any_w;

  // Last beat of a full burst
  wire last_beat_w = (count_r == LAST_BEAT);

  // Cycle ends on release after use, or after four beats
  wire end_w = (engaged_r && all_high_w) || (beat_w && last_beat_w);

  // ----------------------------------------------------------------
  // Address path
  // ----------------------------------------------------------------
  // Upper address is transparent while enables are high
  wire [UPPER_W-1:0] upper_w = all_high_w ? link.address[ADDR_W-1:UPPER_LSB] : upper_r;

  // Interleaved offset: start offset XOR beat count
  wire [OFFS_W-1:0] offset_w = start_off_r ^ count_r;

  // Internal word address; the bus address is not used mid-burst
  wire [ADDR_W-1:0] word_addr_w = {upper_w, offset_w};

  // ----------------------------------------------------------------
  // Next-state decode
  // ----------------------------------------------------------------
  // New initialisation wins over ending
  always_comb begin
    active_nxt = active_r;
    if (init_w) begin
      active_nxt = 1'b1;
    end else if (end_w) begin
      active_nxt = 1'b0;
    end
  end

  // Remember that an enable has been taken low
  always_comb begin
    engaged_nxt = engaged_r;
    if (init_w) begin
      engaged_nxt = 1'b0;
    end else if (active_r && any_low_w) begin
      engaged_nxt = 1'b1;
    end
  end

  // Burst counter: cleared on init, stepped on each beat
  always_comb begin
    count_nxt = count_r;
    if (init_w) begin
      count_nxt = OFFS_RESET;
    end else if (beat_w) begin
      count_nxt = count_r + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Cycle tracking
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_r <= 1'b0;
      engaged_r <= 1'b0;
      count_r <= OFFS_RESET;
    end else begin
      active_r <= active_nxt;
      engaged_r <= engaged_nxt;
      count_r <= count_nxt;
    end
  end

  // Starting offset loaded from the two low address bits
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_off_r <= OFFS_RESET;
    end else if (init_w) begin
      start_off_r <= link.address[OFFS_W-1:0];
    end
  end

  // Upper address latch holds once any enable goes low
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upper_r <= '0;
    end else begin
      upper_r <= upper_w;
    end
  end

  // ----------------------------------------------------------------
  // Storage banks
  // ----------------------------------------------------------------
  // Per-bank write strobes and read words
  logic [NUM_BANKS-1:0] bank_wr_w;
  logic [DATA_W-1:0] bank_word_w [NUM_BANKS];

  // Bank A and bank B each take their own write enable
  assign bank_wr_w[BANK_A] = wr_pulse_w && wr_a_w;
  assign bank_wr_w[BANK_B] = wr_pulse_w && wr_b_w;

  // One array per bank, parity bits stored beside data
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic [DATA_W-1:0] mem [DEPTH];

    // Write data taken straight off the bus on the pulse edge
    always_ff @(posedge clk_sys_i) begin
      if (bank_wr_w[b] && lo_byte_w) begin
        mem[word_addr_w][BYTE_W-1:0] <= link.wr_data[BYTE_W-1:0];
      end
      if (bank_wr_w[b] && hi_byte_w) begin
        mem[word_addr_w][DATA_W-1:BYTE_W] <= link.wr_data[DATA_W-1:BYTE_W];
      end
    end

    // Addressed word of this bank
    assign bank_word_w[b] = mem[word_addr_w];
  end

  // Word of the bank whose read enable is low
  wire [DATA_W-1:0] rd_sel_w = rd_b_w ? bank_word_w[BANK_B] : bank_word_w[BANK_A];

  // ----------------------------------------------------------------
  // Read output
  // ----------------------------------------------------------------
  // One word per read beat, shown the cycle after
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_beat_w;
      if (rd_beat_w) begin
        rd_data_r <= rd_sel_w;
      end
    end
  end

  // Drive the link
  assign link.rd_data = rd_data_r;
  assign link.rd_valid = rd_valid_r;

endmodule

/* File: twbc_assertions.sv */
`timescale 1ns/10ps
// --------------------
// Link checker
// --------------------
module twbc_assertions (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic cycle_start_strobe_n,
  input wire logic transfer_done_n,
  input wire logic burst_continue_n,
  input wire logic bank_a_read_enable_n,
  input wire logic bank_b_read_enable_n,
  input wire logic bank_a_write_enable_n,
  input wire logic bank_b_write_enable_n,
  input wire logic [twbc_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_valid
);
  import twbc_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic active_r; // Cycle open after init
  logic [OFFS_W-1:0] beat_cnt_r; // Beats taken so far
  wire logic all_hi_w = bank_a_read_enable_n && bank_b_read_enable_n && bank_a_write_enable_n && bank_b_write_enable_n;
  wire logic rd_low_w = !bank_a_read_enable_n || !bank_b_read_enable_n;
  wire logic init_w = !cycle_start_strobe_n && all_hi_w;
  wire logic beat_w = active_r && !all_hi_w && cycle_start_strobe_n && !(transfer_done_n && burst_continue_n);
  // Follow the open cycle; a fourth beat closes it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_r <= 1'b0;
      beat_cnt_r <= OFFS_RESET;
    end else if (init_w) begin
      active_r <= 1'b1;
      beat_cnt_r <= OFFS_RESET;
    end else if (beat_w) begin
      active_r <= (beat_cnt_r != LAST_BEAT);
      beat_cnt_r <= beat_cnt_r + 2'h1;
    end else if (all_hi_w) begin
      active_r <= 1'b0;
    end
  end
  // --------------------
  // Sequences and properties
  // --------------------
  sequence s_init;
    init_w;
  endsequence
  sequence s_rd_beat;
    beat_w && rd_low_w;
  endsequence
  property p_init_quiet; !cycle_start_strobe_n |-> all_hi_w; endproperty
  property p_rd_answer; s_rd_beat |=> rd_valid; endproperty
  property p_no_stray; !(beat_w && rd_low_w) |=> !rd_valid; endproperty
  property p_burst_four; s_init ##1 s_rd_beat[*4] |=> rd_valid ##1 !rd_valid; endproperty
  property p_single_end; s_init ##1 s_rd_beat ##1 all_hi_w |-> rd_valid ##1 !rd_valid; endproperty
  property p_stream; s_rd_beat[*2] |-> rd_valid ##1 rd_valid; endproperty
  property p_one_read; !(!bank_a_read_enable_n && !bank_b_read_enable_n); endproperty
  property p_one_write; !(!bank_a_write_enable_n && !bank_b_write_enable_n); endproperty
  property p_wr_ready; active_r && !all_hi_w && cycle_start_strobe_n |-> !burst_continue_n; endproperty
  property p_hold_data; !rd_valid |-> $stable(rd_data); endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("strobe with enable low");
  a_rd_answer: assert property (p_rd_answer) else $error("read beat without word");
  a_no_stray: assert property (p_no_stray) else $error("word without read beat");
  a_burst_four: assert property (p_burst_four) else $error("burst not ended at four");
  a_single_end: assert property (p_single_end) else $error("single read not ended");
  a_stream: assert property (p_stream) else $error("burst words not each clock");
  a_one_read: assert property (p_one_read) else $error("both reads low");
  a_one_write: assert property (p_one_write) else $error("both writes low");
  a_wr_ready: assert property (p_wr_ready) else $error("enable low without ready");
  a_hold_data: assert property (p_hold_data) else $error("read word moved");
endmodule

/* File: twbc_tb.sv */
`timescale 1ns/10ps
module tb;
  import twbc_pkg::*;
  localparam logic [71:0] LINE_A = {18'h30303, 18'h20202, 18'h10101, 18'h0a5a5};
  localparam logic [53:0] BYTE_DATA = {18'h15555, 18'h00000, 18'h3ffff};
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0;
  logic req_write_i = 1'b0;
  logic req_bank_i = 1'b0;
  logic req_burst_i = 1'b0;
  logic [1:0] req_byte_en_i = 2'h0;
  logic [ADDR_W-1:0] req_addr_i = 13'h0000;
  logic [71:0] wr_line_i = 72'h0;
  logic busy_o;
  logic done_o;
  logic [71:0] rd_line_o;
  int errors = 0;
  int check_count = 0;
  // 40 MHz clock
  always #12.5 clk_sys_i = ~clk_sys_i;
  // --------------------
  // Both ends, a raw link and the checker
  // --------------------
  twbc_if i_twbc_if ();
  twbc_if i_twbc_if2 ();
  twbc_dev i_twbc_dev (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(i_twbc_if.dev));
  twbc_dev i_twbc_dev2 (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(i_twbc_if2.dev));
  twbc_ctl i_twbc_ctl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req_i), .req_write_i(req_write_i),
    .req_bank_i(req_bank_i), .req_burst_i(req_burst_i), .req_byte_en_i(req_byte_en_i),
    .req_addr_i(req_addr_i), .wr_line_i(wr_line_i), .busy_o(busy_o), .done_o(done_o),
    .rd_line_o(rd_line_o), .link(i_twbc_if.ctl));
  twbc_assertions i_twbc_assertions (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .cycle_start_strobe_n(i_twbc_if.cycle_start_strobe_n), .transfer_done_n(i_twbc_if.transfer_done_n),
    .burst_continue_n(i_twbc_if.burst_continue_n), .bank_a_read_enable_n(i_twbc_if.bank_a_read_enable_n),
    .bank_b_read_enable_n(i_twbc_if.bank_b_read_enable_n),
    .bank_a_write_enable_n(i_twbc_if.bank_a_write_enable_n),
    .bank_b_write_enable_n(i_twbc_if.bank_b_write_enable_n),
    .rd_data(i_twbc_if.rd_data), .rd_valid(i_twbc_if.rd_valid));
  // --------------------
  // Shared tasks
  // --------------------
  task automatic complete_run();
    $display("Counts: checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Compare one word
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One user request, waits for done under a bound
  task automatic req(input logic wr, input logic bk, input logic bu, input logic [1:0] be,
                     input logic [ADDR_W-1:0] a, input logic [71:0] line);
    int n;
    @(negedge clk_sys_i);
    req_i = 1'b1;
    req_write_i = wr;
    req_bank_i = bk;
    req_burst_i = bu;
    req_byte_en_i = be;
    req_addr_i = a;
    wr_line_i = line;
    @(negedge clk_sys_i);
    req_i = 1'b0;
    chk({16'h0, busy_o, i_twbc_if.cycle_start_strobe_n}, 18'h2);
    n = 0;
    while (done_o !== 1'b1 && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 40) begin
      errors++;
      complete_run();
    end
  endtask
  // Single read
  task automatic rd(input logic bk, input logic [ADDR_W-1:0] a);
    req(1'b0, bk, 1'b0, 2'h3, a, 72'h0);
  endtask
  // Raw link controls, changed at the falling edge
  task automatic raw(input logic s, input logic oe, input logic we, input logic cn, input logic dn);
    @(negedge clk_sys_i);
    i_twbc_if2.cycle_start_strobe_n = s;
    i_twbc_if2.bank_a_read_enable_n = oe;
    i_twbc_if2.bank_a_write_enable_n = we;
    i_twbc_if2.burst_continue_n = cn;
    i_twbc_if2.transfer_done_n = dn;
  endtask
  // --------------------
  // Scenarios
  // --------------------
  task automatic t_burst();
    // Burst from offset 1, then single reads probe the order
    req(1'b1, BANK_A, 1'b1, 2'h3, 13'h0105, LINE_A);
    req(1'b0, BANK_A, 1'b1, 2'h3, 13'h0105, 72'h0);
    for (int k = 0; k < BURST_LEN; k++) begin
      chk(rd_line_o[DATA_W*k +: DATA_W], LINE_A[DATA_W*k +: DATA_W]);
    end
    rd(BANK_A, 13'h0106);
    chk(rd_line_o[17:0], LINE_A[71:54]);
    rd(BANK_A, 13'h0104);
    chk(rd_line_o[17:0], LINE_A[35:18]);
    $display("Test burst done");
  endtask
  task automatic t_banks();
    // Same index in both ways, plus the last word
    req(1'b1, BANK_B, 1'b0, 2'h3, 13'h0104, {54'h0, 18'h2c3c3});
    req(1'b1, BANK_B, 1'b0, 2'h3, 13'h1fff, {54'h0, 18'h1e1e1});
    rd(BANK_A, 13'h0104);
    chk(rd_line_o[17:0], LINE_A[35:18]);
    rd(BANK_B, 13'h0104);
    chk(rd_line_o[17:0], 18'h2c3c3);
    rd(BANK_B, 13'h1fff);
    chk(rd_line_o[17:0], 18'h1e1e1);
    $display("Test banks done");
  endtask
  task automatic t_bytes();
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] d;
    logic [1:0] be;
    w = 18'h2c3c3;
    // Upper only, lower only, then no byte at all
    for (int k = 0; k < 3; k++) begin
      be = 2'h2 >> k;
      d = BYTE_DATA[DATA_W*k +: DATA_W];
      req(1'b1, BANK_B, 1'b0, be, 13'h0104, {54'h0, d});
      if (be[1]) begin
        w[17:9] = d[17:9];
      end
      if (be[0]) begin
        w[8:0] = d[8:0];
      end
      rd(BANK_B, 13'h0104);
      chk(rd_line_o[17:0], w);
    end
    $display("Test bytes done");
  endtask
  task automatic t_raw();
    // Fill four words by hand on the raw link
    raw(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    i_twbc_if2.address = 13'h0a40;
    for (int k = 0; k < BURST_LEN; k++) begin
      raw(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
      i_twbc_if2.wr_data = LINE_A[DATA_W*k +: DATA_W];
    end
    raw(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    i_twbc_if2.wr_data = ~i_twbc_if2.wr_data;
    // Read, stall by strobe with continue low and a foreign address, resume by transfer done
    raw(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    raw(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    raw(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    i_twbc_if2.address = 13'h1555;
    chk(i_twbc_if2.rd_data, LINE_A[17:0]);
    raw(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    chk({17'h0, i_twbc_if2.rd_valid}, 18'h0);
    raw(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    chk(i_twbc_if2.rd_data, LINE_A[35:18]);
    $display("Test interrupted burst done");
  endtask
  // --------------------
  // Main sequence
  // --------------------
  initial begin
    i_twbc_if2.cycle_start_strobe_n = 1'b1;
    i_twbc_if2.transfer_done_n = 1'b1;
    i_twbc_if2.burst_continue_n = 1'b1;
    i_twbc_if2.bank_a_read_enable_n = 1'b1;
    i_twbc_if2.bank_b_read_enable_n = 1'b1;
    i_twbc_if2.bank_a_write_enable_n = 1'b1;
    i_twbc_if2.bank_b_write_enable_n = 1'b1;
    i_twbc_if2.upper_byte_enable_n = 1'b0;
    i_twbc_if2.lower_byte_enable_n = 1'b0;
    i_twbc_if2.address = 13'h0000;
    i_twbc_if2.wr_data = 18'h00000;
    repeat (20) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    t_burst();
    t_banks();
    t_bytes();
    t_raw();
    complete_run();
  end
endmodule
